// [verilog/efs_pkg.sv]
// constants of the error flag and event status bank
package efs_pkg;
	localparam int WORD_W = 16;
	localparam int ADDR_W = 8;
	localparam int CHANNELS = 4;
	localparam logic [ADDR_W-1:0] ERROR_FLAG_WORD_ADDR = 8'h00;
	localparam logic [ADDR_W-1:0] CHANNEL1_EVENT_WORD_ADDR = 8'h01;
	localparam logic [ADDR_W-1:0] RANGE_ERROR_LOCATION_ADDR = 8'hFC;
	localparam int FLAG_SUMMARY = 0;
	localparam int FLAG_RANGE = 1;
	localparam int FLAG_SUPPLY = 2;
	localparam int FLAG_BACKUP = 3;
	localparam int FLAG_TUNE0 = 4;
	localparam int FLAG_ADJUST = 8;
	localparam int FLAG_JUNCTION = 9;
	localparam int FLAG_CONVERT = 10;
	localparam int EVT_OVER = 0;
	localparam int EVT_UNDER = 1;
	localparam int EVT_JUNCTION = 2;
	localparam int EVT_CONVERT = 3;
	localparam int EVT_ALARM0 = 4;
	localparam int EVT_LOOP = 8;
	localparam int EVT_HEATER = 9;
	localparam int EVT_OFFCUR = 10;
	localparam logic [WORD_W-1:0] FLAG_RESET = 16'h0000;
	localparam logic [WORD_W-1:0] EVENT_RESET = 16'h0000;
	localparam logic [WORD_W-1:0] RANGE_LOC_RESET = 16'h0000;
	localparam logic [WORD_W-1:0] UNUSED_READ = 16'h0000;
endpackage

// [verilog/efs_status.sv]
// error flag word, channel 1 event word and range error location
`timescale 1ns/1ps
module efs_status
	import efs_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// host buffer memory read port
	input wire logic [ADDR_W-1:0] buffer_memory_word_addr,
	output logic [WORD_W-1:0] buffer_memory_word_rdata,
	// host writes checked by the setting store
	input wire logic setting_write,
	input wire logic setting_out_of_range,
	input wire logic [WORD_W-1:0] setting_word_number,
	// error reset command pulse
	input wire logic error_reset,
	// device error causes
	input wire logic supply_missing,
	input wire logic backup_failed,
	input wire logic backup_busy,
	input wire logic backup_command,
	input wire logic [CHANNELS-1:0] tuning_abnormal_end,
	input wire logic adjust_data_error,
	// channel 1 causes
	input wire logic input_over_scale,
	input wire logic input_under_scale,
	input wire logic junction_data_error,
	input wire logic convert_value_error,
	input wire logic [3:0] alarm_active,
	input wire logic loop_break_alarm,
	input wire logic heater_break_alarm,
	input wire logic off_current_error,
	// monitor copies for peripheral equipment
	output logic [WORD_W-1:0] error_flag_word,
	output logic [WORD_W-1:0] channel1_event_word,
	output logic [WORD_W-1:0] range_error_location
);
	logic backup_command_d;
	logic [WORD_W-1:0] flag_cause;
	logic [WORD_W-1:0] next_flag;
	logic [WORD_W-1:0] event_cause;
	logic [WORD_W-1:0] next_event;
	logic range_hit;
	logic backup_abort;

	// bank decode used by read mux
	function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
		return a == b;
	endfunction

	assign range_hit = setting_write & setting_out_of_range;
	// backup command dropped while the backup still runs
	assign backup_abort = backup_command_d & ~backup_command & backup_busy;

	always_comb begin
		flag_cause = '0;
		flag_cause[FLAG_RANGE] = range_hit;
		flag_cause[FLAG_SUPPLY] = supply_missing;
		flag_cause[FLAG_BACKUP] = backup_failed | backup_abort;
		flag_cause[FLAG_TUNE0 +: CHANNELS] = tuning_abnormal_end;
		flag_cause[FLAG_ADJUST] = adjust_data_error;
		flag_cause[FLAG_JUNCTION] = junction_data_error;
		flag_cause[FLAG_CONVERT] = convert_value_error;
	end

	always_comb begin
		event_cause = '0;
		event_cause[EVT_OVER] = input_over_scale;
		event_cause[EVT_UNDER] = input_under_scale;
		event_cause[EVT_JUNCTION] = junction_data_error;
		event_cause[EVT_CONVERT] = convert_value_error;
		event_cause[EVT_ALARM0 +: 4] = alarm_active;
		event_cause[EVT_LOOP] = loop_break_alarm;
		event_cause[EVT_HEATER] = heater_break_alarm;
		event_cause[EVT_OFFCUR] = off_current_error;
	end

	// sticky bits; a cause present during reset wins over the clear
	logic [WORD_W-1:0] flag_kept;
	logic [WORD_W-1:0] event_kept;
	assign flag_kept = error_reset ? '0 : error_flag_word;
	assign event_kept = error_reset ? '0 : channel1_event_word;

	always_comb begin
		next_flag = flag_kept | flag_cause;
		next_flag[FLAG_SUMMARY] = |next_flag[FLAG_CONVERT:FLAG_RANGE];
		next_flag[WORD_W-1:FLAG_CONVERT+1] = '0;
		next_event = event_kept | event_cause;
		next_event[WORD_W-1:EVT_OFFCUR+1] = '0;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			error_flag_word <= FLAG_RESET;
			channel1_event_word <= EVENT_RESET;
			range_error_location <= RANGE_LOC_RESET;
			backup_command_d <= 1'b0;
		end else begin
			error_flag_word <= next_flag;
			channel1_event_word <= next_event;
			backup_command_d <= backup_command;
			if (range_hit) begin
				range_error_location <= setting_word_number;
			end
		end
	end

	// read map for the host
	wire sel_flag = is_addr(buffer_memory_word_addr, ERROR_FLAG_WORD_ADDR);
	wire sel_evt = is_addr(buffer_memory_word_addr, CHANNEL1_EVENT_WORD_ADDR);
	wire sel_loc = is_addr(buffer_memory_word_addr, RANGE_ERROR_LOCATION_ADDR);
	assign buffer_memory_word_rdata = sel_flag ? error_flag_word :
		sel_evt ? channel1_event_word :
		sel_loc ? range_error_location : UNUSED_READ;

	a_summary_bit: assert property (@(posedge sys_clk) disable iff (!rstn)
		error_flag_word[FLAG_SUMMARY] == |error_flag_word[FLAG_CONVERT:FLAG_RANGE])
		else $error("summary bit disagrees with flag bits");
	a_range_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
		range_hit |=> error_flag_word[FLAG_RANGE] && error_flag_word[FLAG_SUMMARY])
		else $error("range flag not set");
	a_range_location: assert property (@(posedge sys_clk) disable iff (!rstn)
		range_hit |=> range_error_location == $past(setting_word_number))
		else $error("range location not stored");
	a_supply_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
		supply_missing |=> error_flag_word[FLAG_SUPPLY])
		else $error("supply flag not set");
	a_backup_abort: assert property (@(posedge sys_clk) disable iff (!rstn)
		backup_command ##1 (!backup_command && backup_busy) |=> error_flag_word[FLAG_BACKUP])
		else $error("backup abort not flagged");
	a_tune_flags: assert property (@(posedge sys_clk) disable iff (!rstn)
		|tuning_abnormal_end |=> (error_flag_word[FLAG_TUNE0 +: CHANNELS]
		& $past(tuning_abnormal_end)) == $past(tuning_abnormal_end))
		else $error("tuning flag missing");
	a_event_follow: assert property (@(posedge sys_clk) disable iff (!rstn)
		1'b1 |=> (channel1_event_word & $past(event_cause)) == $past(event_cause))
		else $error("event bit missing");
	a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
		(!error_reset && error_flag_word[FLAG_SUPPLY]) |=> error_flag_word[FLAG_SUPPLY])
		else $error("flag dropped without reset");
	a_reset_clears: assert property (@(posedge sys_clk) disable iff (!rstn)
		(error_reset && flag_cause == '0) |=> error_flag_word == '0)
		else $error("error reset did not clear");

	// flag word causes
	a_backup_fail: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		backup_failed |=> error_flag_word[FLAG_BACKUP]
	) else $error("backup failure not flagged");

	a_adjust_flag: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		adjust_data_error |=> error_flag_word[FLAG_ADJUST]
	) else $error("adjustment data flag not set");

	a_junction_flag: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		junction_data_error |=> error_flag_word[FLAG_JUNCTION]
	) else $error("junction data flag not set");

	a_convert_flag: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		convert_value_error |=> error_flag_word[FLAG_CONVERT]
	) else $error("converter flag not set");

	generate
		for (genvar c = 0; c < CHANNELS; c++) begin : g_tune_bit
			a_tune_bit: assert property (
				@(posedge sys_clk) disable iff (!rstn)
				tuning_abnormal_end[c] |=> error_flag_word[FLAG_TUNE0 + c]
			) else $error("channel tuning flag not set");
		end
	endgenerate

	a_flag_upper_zero: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		error_flag_word[WORD_W-1:FLAG_CONVERT+1] == '0
	) else $error("unused flag bits set");

	a_in_range_write: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		setting_write && !setting_out_of_range && !error_reset
		|=> error_flag_word[FLAG_RANGE] == $past(error_flag_word[FLAG_RANGE])
	) else $error("in-range write changed range flag");

	a_location_hold: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		!range_hit |=> range_error_location == $past(range_error_location)
	) else $error("range location changed without error");

	// event word causes
	a_over_event: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		input_over_scale |=> channel1_event_word[EVT_OVER]
	) else $error("over scale event not set");

	a_under_event: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		input_under_scale |=> channel1_event_word[EVT_UNDER]
	) else $error("under scale event not set");

	a_junction_event: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		junction_data_error |=> channel1_event_word[EVT_JUNCTION]
	) else $error("junction event not set");

	a_convert_event: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		convert_value_error |=> channel1_event_word[EVT_CONVERT]
	) else $error("converter event not set");

	a_alarm_events: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		alarm_active != 4'h0
		|=> (channel1_event_word[EVT_ALARM0 +: 4] & $past(alarm_active)) == $past(alarm_active)
	) else $error("alarm events missing");

	generate
		for (genvar k = 0; k < 4; k++) begin : g_alarm_bit
			a_alarm_bit: assert property (
				@(posedge sys_clk) disable iff (!rstn)
				alarm_active[k] |=> channel1_event_word[EVT_ALARM0 + k]
			) else $error("alarm event bit not set");
		end
	endgenerate

	a_loop_event: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		loop_break_alarm |=> channel1_event_word[EVT_LOOP]
	) else $error("loop break event not set");

	a_heater_event: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		heater_break_alarm |=> channel1_event_word[EVT_HEATER]
	) else $error("heater break event not set");

	a_offcur_event: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		off_current_error |=> channel1_event_word[EVT_OFFCUR]
	) else $error("off current event not set");

	a_event_upper_zero: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		channel1_event_word[WORD_W-1:EVT_OFFCUR+1] == '0
	) else $error("unused event bits set");

	// read map
	a_read_flag: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		buffer_memory_word_addr == ERROR_FLAG_WORD_ADDR |-> buffer_memory_word_rdata == error_flag_word
	) else $error("flag word read wrong");

	a_read_event: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		buffer_memory_word_addr == CHANNEL1_EVENT_WORD_ADDR
		|-> buffer_memory_word_rdata == channel1_event_word
	) else $error("event word read wrong");

	a_read_location: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		buffer_memory_word_addr == RANGE_ERROR_LOCATION_ADDR
		|-> buffer_memory_word_rdata == range_error_location
	) else $error("range location read wrong");

	a_read_unused: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		buffer_memory_word_addr != ERROR_FLAG_WORD_ADDR
		&& buffer_memory_word_addr != CHANNEL1_EVENT_WORD_ADDR
		&& buffer_memory_word_addr != RANGE_ERROR_LOCATION_ADDR
		|-> buffer_memory_word_rdata == UNUSED_READ
	) else $error("unmapped read not zero");

	// sticky bits and error reset
	generate
		for (genvar b = FLAG_RANGE; b <= FLAG_CONVERT; b++) begin : g_flag_hold
			a_flag_hold: assert property (
				@(posedge sys_clk) disable iff (!rstn)
				!error_reset && error_flag_word[b] |=> error_flag_word[b]
			) else $error("flag bit dropped without reset");
		end
	endgenerate

	generate
		for (genvar e = EVT_OVER; e <= EVT_OFFCUR; e++) begin : g_event_hold
			a_event_hold: assert property (
				@(posedge sys_clk) disable iff (!rstn)
				!error_reset && channel1_event_word[e] |=> channel1_event_word[e]
			) else $error("event bit dropped without reset");
		end
	endgenerate

	a_event_clear: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		error_reset && event_cause == '0 |=> channel1_event_word == '0
	) else $error("error reset did not clear events");

	a_supply_reset_win: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		error_reset && supply_missing |=> error_flag_word[FLAG_SUPPLY]
	) else $error("present supply cause lost at reset");

	a_backup_reset_win: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		error_reset && backup_failed |=> error_flag_word[FLAG_BACKUP]
	) else $error("present backup cause lost at reset");

	a_range_reset_win: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		error_reset && range_hit |=> error_flag_word[FLAG_RANGE] && error_flag_word[FLAG_SUMMARY]
	) else $error("range error lost at reset");

	a_convert_reset_win: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		error_reset && convert_value_error
		|=> error_flag_word[FLAG_CONVERT] && channel1_event_word[EVT_CONVERT]
	) else $error("present converter cause lost at reset");

	a_alarm_reset_win: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		error_reset && alarm_active[0] |=> channel1_event_word[EVT_ALARM0]
	) else $error("present alarm cause lost at reset");
endmodule

// [tb/efs_host.sv]
// host model that reads buffer memory words of the status bank
`timescale 1ns/1ps
module efs_host
	import efs_pkg::*;
(
	// clock
	input wire logic sys_clk,
	// buffer memory read port
	output logic [ADDR_W-1:0] buffer_memory_word_addr,
	input wire logic [WORD_W-1:0] buffer_memory_word_rdata
);
	initial buffer_memory_word_addr = 8'h02;
	task automatic read_word(input logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] d);
		@(posedge sys_clk);
		#1 buffer_memory_word_addr = a;
		#5 d = buffer_memory_word_rdata;
	endtask
endmodule

// [tb/efs_status_tb.sv]
// self-checking bench of the error flag and event status bank
`timescale 1ns/1ps
module efs_status_tb
	import efs_pkg::*;
;
	logic sys_clk = 0, rstn = 0, setting_write = 0, setting_out_of_range = 0, error_reset = 0;
	logic backup_busy = 0, backup_command = 0;
	logic [WORD_W-1:0] setting_word_number = 16'h0000, rd, ef, ev;
	logic [17:0] cause = 18'h00000;
	wire logic [ADDR_W-1:0] addr;
	wire logic [WORD_W-1:0] rdata, flag_w, evt_w, loc_w;
	int fail_count = 0, n_compared = 0, cycles = 0, i;
	always #12.5 sys_clk = ~sys_clk;
	efs_host host (.sys_clk(sys_clk), .buffer_memory_word_addr(addr),
		.buffer_memory_word_rdata(rdata));
	efs_status DUT (.sys_clk(sys_clk), .rstn(rstn), .buffer_memory_word_addr(addr),
		.buffer_memory_word_rdata(rdata), .setting_write(setting_write),
		.setting_out_of_range(setting_out_of_range), .setting_word_number(setting_word_number),
		.error_reset(error_reset), .supply_missing(cause[0]), .backup_failed(cause[1]),
		.backup_busy(backup_busy), .backup_command(backup_command),
		.tuning_abnormal_end(cause[5:2]), .adjust_data_error(cause[6]),
		.input_over_scale(cause[9]), .input_under_scale(cause[10]),
		.junction_data_error(cause[7]), .convert_value_error(cause[8]),
		.alarm_active(cause[14:11]), .loop_break_alarm(cause[15]),
		.heater_break_alarm(cause[16]), .off_current_error(cause[17]),
		.error_flag_word(flag_w), .channel1_event_word(evt_w), .range_error_location(loc_w));
	task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic clear_all;
		error_reset = 1;
		tick;
		error_reset = 0;
		tick;
	endtask
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			final_report;
		end
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		#1 rstn = 1;
		host.read_word(ERROR_FLAG_WORD_ADDR, rd);
		check(rd, FLAG_RESET);
		host.read_word(8'h02, rd);
		check(rd, UNUSED_READ);
		// each cause pulsed once, then held bits checked and cleared
		for (i = 0; i < 18; i++) begin
			cause[i] = 1'b1;
			tick;
			cause = 18'h00000;
			tick;
			ef = (i < 9) ? (16'h0001 | (16'h0001 << (i + 2))) : 16'h0000;
			ev = 16'h0000;
			if (i == 7 || i == 8) ev = 16'h0001 << (i - 5);
			else if (i == 9 || i == 10) ev = 16'h0001 << (i - 9);
			else if (i > 10) ev = 16'h0001 << (i - 7);
			host.read_word(ERROR_FLAG_WORD_ADDR, rd);
			check(rd, ef);
			host.read_word(CHANNEL1_EVENT_WORD_ADDR, rd);
			check(rd, ev);
			check(flag_w, ef);
			clear_all;
			check(flag_w | evt_w, 16'h0000);
			$display("test cause %0d done", i);
		end
		setting_write = 1;
		setting_out_of_range = 1;
		setting_word_number = 16'h00AB;
		tick;
		setting_out_of_range = 0;
		setting_word_number = 16'h0055;
		tick;
		setting_write = 0;
		tick;
		host.read_word(ERROR_FLAG_WORD_ADDR, rd);
		check(rd, 16'h0003);
		host.read_word(RANGE_ERROR_LOCATION_ADDR, rd);
		check(rd, 16'h00AB);
		check(loc_w, 16'h00AB);
		clear_all;
		$display("test range done");
		backup_busy = 1;
		backup_command = 1;
		tick;
		backup_command = 0;
		tick;
		backup_busy = 0;
		tick;
		check(flag_w, 16'h0009);
		clear_all;
		cause[0] = 1'b1;
		tick;
		clear_all;
		check(flag_w, 16'h0005);
		cause = 18'h00000;
		clear_all;
		check(flag_w, 16'h0000);
		$display("test backup and held cause done");
		final_report;
	end
endmodule
